// >>> rtl/sscb_bank.sv
// safety control and status bits with secure-write unlock
`include "sscb_map.svh"
module sscb_bank
    import sscb_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = `SSCB_UNLOCK_TIMEOUT_CYC,
    parameter int TIMER_W = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire sscb_req_type reg_req,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] selftest_ov_set,
    input wire logic [6:0] selftest_uv_set,
    input wire logic [4:0] failsafe_set,
    input wire logic thermal_alarm_pin,
    input wire logic vin_overvolt_pin,
    input wire logic wdog_input_pin,
    input wire logic standby_mode,
    output logic selftest_start,
    output logic thermal_event,
    output logic input_overvolt_irq,
    output logic input_overvolt_shutdown,
    output logic wdog_counter_run,
    output logic wdog_soft_reset,
    output logic wdog_hard_reset,
    output logic [6:0] regulator_monitor_enable,
    output logic secure_pending
);
    generate
        if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << TIMER_W)) begin : g_bad_timeout
            $error("timeout count does not fit the timer");
        end
    endgenerate

    localparam logic [TIMER_W-1:0] TIMEOUT_LAST = TIMER_W'(TIMEOUT_CYCLES - 1);

    // register state
    logic [4:0] st_uv_a_ff;
    logic [1:0] st_uv_b_ff;
    logic [4:0] st_ov_a_ff;
    logic [1:0] st_ov_b_ff;
    logic [4:0] fs_flags_ff;
    logic [7:0] ctrl_one_ff;
    logic [4:0] vmon_a_ff;
    logic [1:0] vmon_b_ff;
    logic selftest_start_ff;
    logic [7:0] reg_rdata_ff;

    // unlock state
    sscb_state_type state_ff;
    sscb_state_type nxt_state;
    logic [7:0] lfsr_ff;
    logic [7:0] gen_code_ff;
    logic [7:0] nxt_gen_code;
    logic [7:0] pend_addr_ff;
    logic [7:0] pend_data_ff;
    logic [TIMER_W-1:0] timer_ff;
    logic [TIMER_W-1:0] nxt_timer;

    // pin synchronisers: stage one feeds only stage two
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_meta_ff <= 3'h0;
            pin_sync_ff <= 3'h0;
        end else if (clk_en) begin
            pin_meta_ff <= {wdog_input_pin, vin_overvolt_pin, thermal_alarm_pin};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    wire thermal_sync = pin_sync_ff[0];
    wire vin_ov_sync = pin_sync_ff[1];
    wire wdi_sync = pin_sync_ff[2];

    // write path decode
    wire secure_en = ctrl_one_ff[`SSCB_BIT_SECURE_EN];
    wire req_secure = reg_req.wr && (reg_req.addr <= `SSCB_OFS_VMON_B);
    wire req_check = reg_req.wr && (reg_req.addr == `SSCB_OFS_RET_CODE);
    wire waiting = (state_ff == SSCB_WAIT_CHECK);
    wire code_match = waiting && req_check && (reg_req.wdata == gen_code_ff);
    wire direct_apply = req_secure && !secure_en;
    wire start_pending = req_secure && secure_en;
    wire timed_out = waiting && !reg_req.wr && (timer_ff == TIMEOUT_LAST);
    wire apply_en = code_match || direct_apply;
    wire [7:0] apply_addr = code_match ? pend_addr_ff : reg_req.addr;
    wire [7:0] apply_data = code_match ? pend_data_ff : reg_req.wdata;

    wire wr_uv_a = apply_en && (apply_addr == `SSCB_OFS_ST_UV_A);
    wire wr_uv_b = apply_en && (apply_addr == `SSCB_OFS_ST_UV_B);
    wire wr_ov_a = apply_en && (apply_addr == `SSCB_OFS_ST_OV_A);
    wire wr_ov_b = apply_en && (apply_addr == `SSCB_OFS_ST_OV_B);
    wire wr_run = apply_en && (apply_addr == `SSCB_OFS_ST_RUN);
    wire wr_fs = apply_en && (apply_addr == `SSCB_OFS_FS_FLAGS);
    wire wr_ctrl = apply_en && (apply_addr == `SSCB_OFS_CTRL_ONE);
    wire wr_vmon_a = apply_en && (apply_addr == `SSCB_OFS_VMON_A);
    wire wr_vmon_b = apply_en && (apply_addr == `SSCB_OFS_VMON_B);

    // a zero bit in the data clears nothing, and a new event beats a clear
    wire [4:0] clr_uv_a = wr_uv_a ? apply_data[4:0] : 5'h00;
    wire [1:0] clr_uv_b = wr_uv_b ? apply_data[1:0] : 2'h0;
    wire [4:0] clr_ov_a = wr_ov_a ? apply_data[4:0] : 5'h00;
    wire [1:0] clr_ov_b = wr_ov_b ? apply_data[1:0] : 2'h0;
    wire [4:0] clr_fs = wr_fs ? apply_data[4:0] : 5'h00;
    wire [4:0] nxt_st_uv_a = (st_uv_a_ff & ~clr_uv_a) | selftest_uv_set[4:0];
    wire [1:0] nxt_st_uv_b = (st_uv_b_ff & ~clr_uv_b) | selftest_uv_set[6:5];
    wire [4:0] nxt_st_ov_a = (st_ov_a_ff & ~clr_ov_a) | selftest_ov_set[4:0];
    wire [1:0] nxt_st_ov_b = (st_ov_b_ff & ~clr_ov_b) | selftest_ov_set[6:5];
    wire [4:0] nxt_fs_flags = (fs_flags_ff & ~clr_fs) | failsafe_set;
    wire nxt_selftest_start = wr_run && apply_data[`SSCB_BIT_ST_RUN];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_uv_a_ff <= 5'h00;
            st_uv_b_ff <= 2'h0;
            st_ov_a_ff <= 5'h00;
            st_ov_b_ff <= 2'h0;
            fs_flags_ff <= 5'h00;
            selftest_start_ff <= 1'b0;
        end else if (clk_en) begin
            st_uv_a_ff <= nxt_st_uv_a;
            st_uv_b_ff <= nxt_st_uv_b;
            st_ov_a_ff <= nxt_st_ov_a;
            st_ov_b_ff <= nxt_st_ov_b;
            fs_flags_ff <= nxt_fs_flags;
            selftest_start_ff <= nxt_selftest_start;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_one_ff <= `SSCB_RST_CTRL_ONE;
            vmon_a_ff <= 5'(`SSCB_RST_VMON_A);
            vmon_b_ff <= 2'(`SSCB_RST_VMON_B);
        end else if (clk_en) begin
            if (wr_ctrl) begin
                ctrl_one_ff <= apply_data;
            end
            if (wr_vmon_a) begin
                vmon_a_ff <= apply_data[4:0];
            end
            if (wr_vmon_b) begin
                vmon_b_ff <= apply_data[1:0];
            end
        end
    end

    // unlock sequencer; any other write during the wait cancels the pending one
    always_comb begin
        nxt_state = state_ff;
        nxt_gen_code = gen_code_ff;
        nxt_timer = timer_ff;
        case (state_ff)
            SSCB_IDLE: begin
                if (start_pending) begin
                    nxt_state = SSCB_WAIT_CHECK;
                    nxt_gen_code = lfsr_ff;
                    nxt_timer = '0;
                end
            end
            SSCB_WAIT_CHECK: begin
                nxt_timer = timer_ff + 1'b1;
                if (start_pending) begin
                    nxt_gen_code = lfsr_ff;
                    nxt_timer = '0;
                end else if (reg_req.wr || timed_out) begin
                    nxt_state = SSCB_IDLE;
                    nxt_gen_code = 8'h00;
                    nxt_timer = '0;
                end
            end
            default: begin
                nxt_state = SSCB_IDLE;
            end
        endcase
    end

    // free-running code source; never zero so a cleared code never matches by accident
    wire lfsr_fb = lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_ff <= SSCB_IDLE;
            gen_code_ff <= 8'h00;
            timer_ff <= '0;
            lfsr_ff <= `SSCB_RST_LFSR;
            pend_addr_ff <= 8'h00;
            pend_data_ff <= 8'h00;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            gen_code_ff <= nxt_gen_code;
            timer_ff <= nxt_timer;
            lfsr_ff <= {lfsr_ff[6:0], lfsr_fb};
            if (start_pending) begin
                pend_addr_ff <= reg_req.addr;
                pend_data_ff <= reg_req.wdata;
            end
        end
    end

    // read path, registered one cycle behind the address
    wire [7:0] rd_mux =
        (reg_rd_addr == `SSCB_OFS_ST_UV_A) ? {3'h0, st_uv_a_ff} :
        (reg_rd_addr == `SSCB_OFS_ST_UV_B) ? {6'h00, st_uv_b_ff} :
        (reg_rd_addr == `SSCB_OFS_ST_OV_A) ? {3'h0, st_ov_a_ff} :
        (reg_rd_addr == `SSCB_OFS_ST_OV_B) ? {6'h00, st_ov_b_ff} :
        (reg_rd_addr == `SSCB_OFS_FS_FLAGS) ? {3'h0, fs_flags_ff} :
        (reg_rd_addr == `SSCB_OFS_CTRL_ONE) ? ctrl_one_ff :
        (reg_rd_addr == `SSCB_OFS_VMON_A) ? {3'h0, vmon_a_ff} :
        (reg_rd_addr == `SSCB_OFS_VMON_B) ? {6'h00, vmon_b_ff} :
        (reg_rd_addr == `SSCB_OFS_GEN_CODE) ? gen_code_ff :
        8'h00;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata_ff <= 8'h00;
        end else if (clk_en) begin
            reg_rdata_ff <= rd_mux;
        end
    end

    // control outputs
    wire therm_en = ctrl_one_ff[`SSCB_BIT_THERM_EN];
    wire ovlo_en = ctrl_one_ff[`SSCB_BIT_OVLO_EN];
    wire ovlo_sdwn = ctrl_one_ff[`SSCB_BIT_OVLO_SDWN];
    wire wdog_counter_enable = ctrl_one_ff[`SSCB_BIT_WDOG_COUNTER_ENABLE];
    wire wd_stby = ctrl_one_ff[`SSCB_BIT_WD_STBY];
    wire wdi_stby = ctrl_one_ff[`SSCB_BIT_WDI_STBY];
    wire wdi_hard = ctrl_one_ff[`SSCB_BIT_WDI_TYPE];
    wire wdi_watch = wdi_sync && (!standby_mode || wdi_stby);

    assign reg_rdata = reg_rdata_ff;
    assign selftest_start = selftest_start_ff;
    assign thermal_event = thermal_sync && therm_en;
    assign input_overvolt_irq = vin_ov_sync && ovlo_en;
    assign input_overvolt_shutdown = vin_ov_sync && ovlo_en && ovlo_sdwn;
    assign wdog_counter_run = wdog_counter_enable && (!standby_mode || wd_stby);
    assign wdog_soft_reset = wdi_watch && !wdi_hard;
    assign wdog_hard_reset = wdi_watch && wdi_hard;
    assign regulator_monitor_enable = {vmon_b_ff, vmon_a_ff};
    assign secure_pending = waiting;
endmodule

// >>> rtl/sscb_map.svh
// register offsets, field positions, reset values and timing counts of the safety control bits
// What this block does
// - writing one to a self-test over/undervoltage flag clears that flag
// - writing one to the self-test run bit launches an on-demand analog self-test
// - writing one to a fail-safe cause flag clears that flag
// - thermal monitor enable at zero blocks thermal interrupt and shutdown detection
// - watchdog input event type zero gives soft reset, one gives hard reset
// - input overvoltage lockout enable at zero disables that monitor entirely
// - input overvoltage shutdown bit at zero leaves only the interrupt
// - watchdog enable at zero disables the watchdog counter
// - standby watchdog enable at zero stops the counter in standby
// - standby input monitor bit at zero ignores the watchdog input pin in standby
// - secure-write enable at zero turns off the secure-write handshake
// - each regulator monitor enable at zero disables its over/undervoltage monitoring
// - secure writes apply only when returned code equals generated code; both clear
// - pending secure write is abandoned 10 ms after the code is generated
`ifndef SSCB_MAP_SVH
`define SSCB_MAP_SVH
`define SSCB_OFS_ST_UV_A 8'h00
`define SSCB_OFS_ST_UV_B 8'h01
`define SSCB_OFS_ST_OV_A 8'h02
`define SSCB_OFS_ST_OV_B 8'h03
`define SSCB_OFS_ST_RUN 8'h04
`define SSCB_OFS_FS_FLAGS 8'h05
`define SSCB_OFS_CTRL_ONE 8'h06
`define SSCB_OFS_VMON_A 8'h07
`define SSCB_OFS_VMON_B 8'h08
`define SSCB_OFS_GEN_CODE 8'h09
`define SSCB_OFS_RET_CODE 8'h0A
`define SSCB_BIT_THERM_EN 0
`define SSCB_BIT_WDI_TYPE 1
`define SSCB_BIT_OVLO_EN 2
`define SSCB_BIT_OVLO_SDWN 3
`define SSCB_BIT_WDOG_COUNTER_ENABLE 4
`define SSCB_BIT_WD_STBY 5
`define SSCB_BIT_WDI_STBY 6
`define SSCB_BIT_SECURE_EN 7
`define SSCB_BIT_ST_RUN 0
`define SSCB_RST_CTRL_ONE 8'hDD
`define SSCB_RST_VMON_A 8'h1F
`define SSCB_RST_VMON_B 8'h03
`define SSCB_RST_LFSR 8'h01
`define SSCB_UNLOCK_TIMEOUT_MS 10
`define SSCB_CLK_MHZ 100
`define SSCB_UNLOCK_TIMEOUT_CYC (`SSCB_UNLOCK_TIMEOUT_MS * 1000 * `SSCB_CLK_MHZ)
`endif

// >>> rtl/sscb_pkg.sv
// types shared by the safety control bit bank
package sscb_pkg;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sscb_req_type;

    typedef enum logic {
        SSCB_IDLE,
        SSCB_WAIT_CHECK
    } sscb_state_type;
endpackage

// >>> tb/sscb_bank_tb_top.sv
// self-checking bench for the safety control bit bank
module sscb_bank_tb_top
    import sscb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 20;
    logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    sscb_req_type reg_req;
    logic [7:0] reg_rd_addr, reg_rdata, exp_q[$], v, m, f[6];
    logic [6:0] selftest_ov_set = '0, selftest_uv_set = '0, regulator_monitor_enable;
    logic [4:0] failsafe_set = '0;
    logic thermal_alarm_pin = 0, vin_overvolt_pin = 0, wdog_input_pin = 0, standby_mode = 0;
    logic selftest_start, thermal_event, input_overvolt_irq, input_overvolt_shutdown;
    logic wdog_counter_run, wdog_soft_reset, wdog_hard_reset, secure_pending, rd_tag, rd_seen = 0;
    int fail_count = 0, checks = 0, starts = 0, seed = 15, k;
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    sscb_bank #(.TIMEOUT_CYCLES(TMO)) i_dut (.*);
    sscb_host i_host (.*);
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        i_host.read(a);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge core_clk) rd_seen <= rd_tag;
    always @(posedge core_clk) if (selftest_start) starts++;
    always @(negedge core_clk) if (rd_seen) chk("read data", exp_q.pop_front(), reg_rdata);
    initial begin
        #300000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk) sys_rst = 1'b0;
        for (k = 0; k < 12; k++) begin
            rd(k[7:0], k == 6 ? 8'hDD : k == 7 ? 8'h1F : k == 8 ? 8'h03 : 8'h00);
        end
        chk("monitor enables", 8'h7F, {1'b0, regulator_monitor_enable});
        i_host.write(8'h07, 8'h15, 8'h00);
        rd(8'h07, 8'h15);
        chk("monitor enables", 8'h75, {1'b0, regulator_monitor_enable});
        i_host.write(8'h08, 8'h00, 8'h5A);
        rd(8'h08, 8'h03);
        i_host.put(8'h06, 8'h00);
        chk("pending", 8'h01, {7'h00, secure_pending});
        for (k = 0; k < TMO + 10 && secure_pending; k++) @(negedge core_clk);
        chk("pending", 8'h00, {7'h00, secure_pending});
        if (secure_pending) print_verdict();
        chk("timeout wait", 8'h01, {7'h00, k >= TMO - 3});
        rd(8'h06, 8'hDD);
        i_host.write(8'h06, 8'h5D, 8'h00);
        i_host.secure_on = 1'b0;
        // with the lock off every write lands at once, so the sweep needs no handshake
        for (k = 0; k < 12; k++) begin
            v = $random(seed) & 8'h7F;
            i_host.write(8'h06, v, 8'h00);
            {thermal_alarm_pin, vin_overvolt_pin, wdog_input_pin, standby_mode} = $random(seed);
            repeat (3) @(negedge core_clk);
            m = {2'b00, thermal_alarm_pin & v[0], vin_overvolt_pin & v[2],
                 vin_overvolt_pin & v[2] & v[3], v[4] & (!standby_mode | v[5]),
                 wdog_input_pin & (!standby_mode | v[6]) & !v[1],
                 wdog_input_pin & (!standby_mode | v[6]) & v[1]};
            chk("gated outputs", m, {2'b00, thermal_event, input_overvolt_irq,
                input_overvolt_shutdown, wdog_counter_run, wdog_soft_reset,
                wdog_hard_reset});
        end
        @(negedge core_clk);
        {selftest_uv_set, selftest_ov_set, failsafe_set} = $random(seed);
        f[0] = {3'h0, selftest_uv_set[4:0]};
        f[1] = {6'h00, selftest_uv_set[6:5]};
        f[2] = {3'h0, selftest_ov_set[4:0]};
        f[3] = {6'h00, selftest_ov_set[6:5]};
        f[5] = {3'h0, failsafe_set};
        @(negedge core_clk);
        {selftest_uv_set, selftest_ov_set, failsafe_set} = '0;
        for (k = 0; k < 6; k++) begin
            if (k == 4) continue;
            m = $random(seed);
            i_host.write(k[7:0], 8'h00, 8'h00);
            rd(k[7:0], f[k]);
            i_host.write(k[7:0], m, 8'h00);
            rd(k[7:0], f[k] & ~m);
        end
        i_host.write(8'h04, 8'h00, 8'h00);
        repeat (3) @(negedge core_clk);
        chk("starts", 8'h00, starts[7:0]);
        i_host.write(8'h04, 8'h01, 8'h00);
        repeat (3) @(negedge core_clk);
        chk("starts", 8'h01, starts[7:0]);
        @(negedge core_clk);
        print_verdict();
    end
endmodule

// >>> tb/sscb_host.sv
// host model: issues register writes and follows the unlock handshake
module sscb_host
    import sscb_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata,
    output sscb_req_type reg_req,
    output logic [7:0] reg_rd_addr,
    output logic rd_tag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic secure_on = 1'b1;
    logic [7:0] code;
    initial begin
        reg_req = '0;
        reg_rd_addr = 8'h00;
        rd_tag = 1'b0;
    end
    // idle address and data go inverted so a stale value never passes for a live one
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_req <= '{1'b1, a, d};
        @(negedge core_clk);
        reg_req <= '{1'b0, ~a, ~d};
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d, input logic [7:0] bad);
        put(a, d);
        if (secure_on && a <= 8'h08) begin
            reg_rd_addr <= 8'h09;
            @(negedge core_clk);
            code = reg_rdata;
            put(8'h0A, code ^ bad);
        end
    endtask
    task automatic read(input logic [7:0] a);
        @(negedge core_clk);
        reg_rd_addr <= a;
        rd_tag <= 1'b1;
        @(negedge core_clk);
        rd_tag <= 1'b0;
    endtask
endmodule

// >>> tb/sscb_props.sv
// port checker for the safety control bit bank
module sscb_props
    import sscb_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire sscb_req_type reg_req,
    input wire logic [7:0] reg_rd_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic selftest_start,
    input wire logic input_overvolt_irq,
    input wire logic input_overvolt_shutdown,
    input wire logic wdog_soft_reset,
    input wire logic wdog_hard_reset,
    input wire logic secure_pending
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    int wait_ff;
    // idle cycles spent waiting for the returned code; clk_en is held high by the bench
    always_ff @(posedge core_clk) begin
        wait_ff <= (sys_rst || !secure_pending || reg_req.wr) ? 0 : wait_ff + 1;
    end
    a_shutdown_needs_irq: assert property (input_overvolt_shutdown |-> input_overvolt_irq)
        else $error("shutdown without overvoltage interrupt");
    a_reset_kinds_apart: assert property (!(wdog_soft_reset && wdog_hard_reset))
        else $error("soft and hard watchdog reset together");
    a_start_after_write: assert property (
        $rose(selftest_start) |-> $past(reg_req.wr) || $past(reg_req.wr, 2))
        else $error("self-test start without a write");
    a_pending_after_write: assert property ($rose(secure_pending) |-> $past(reg_req.wr))
        else $error("unlock wait without a write");
    a_pending_bounded: assert property (wait_ff <= TIMEOUT_CYCLES + 2)
        else $error("unlock wait not abandoned in time");
    a_code_when_pending: assert property (
        secure_pending && reg_rd_addr == 8'h09 && !reg_req.wr |=> reg_rdata != 8'h00)
        else $error("generated code zero while waiting");
    a_code_idle_zero: assert property (
        !secure_pending && reg_rd_addr == 8'h09 && !reg_req.wr |=> reg_rdata == 8'h00)
        else $error("generated code not cleared when idle");
    a_unreadable_zero: assert property (
        reg_rd_addr >= 8'h0A |=> reg_rdata == 8'h00)
        else $error("returned code or unmapped place reads nonzero");
    c_start: cover property (selftest_start);
    c_unlock_end: cover property ($fell(secure_pending));
    c_hard_reset: cover property (wdog_hard_reset);
    c_shutdown: cover property (input_overvolt_shutdown);
endmodule
bind sscb_bank sscb_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (.*);
